// ==== rtl/tlv_int_unit.sv ====
/*
  Two-level vectored interrupt unit: eight SFRs, request flags, polarity,
  wake-up, frame-sync divider and priority polling with vector output.
  Assumes the core takes a request on ack, and signals return via reti.
*/
// How it works
// - Fifteen sources, two priorities, vectored jumps
// - Vectors from 0003, step eight bytes
// - Ext2-6 on port-one pins 0-4
// - Global enable clear blocks every source
// - Flags hold requests across running handlers
// - Active level re-sets cleared flag
// - Flags set by events, cleared by software
// - Only ext0/1 and timer0/1 flags cleared on service
// - High first, then fixed polling order
// - Priority bit one means high priority
// - Per-source enables, global at bit seven
// - Request flag bit layout ext2-6/time/DSP/RTC
// - Polarity bit one makes pin active high
// - Control register: frame flag, wake bit
// - Wake-up disable bit per wake source
// - DSP request raises the DSP event
// - DSP transmit-control write raises event
// - RTC event needs enables, non-emergency clock
// - RTC event wakes core; software clears
// - Frame event at one eighth or quarter
`timescale 1ns/1ns
module tlv_int_unit
  import tlv_pkg::*;
#(
  parameter int NSRC = TLV_NSRC
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [4:0] port_one_in,
  input wire logic ext_pin_zero_n_in,
  input wire logic ext_pin_one_n_in,
  input wire logic timer_zero_irq_in,
  input wire logic timer_one_irq_in,
  input wire logic modem_serial_irq_in,
  input wire logic i2c_irq_in,
  input wire logic time_event_in,
  input wire logic primary_frame_sync_in,
  input wire logic fs_fast_in,
  input wire logic dsp_to_core_request_in,
  input wire logic dsp_transmit_control_wr_in,
  input wire logic rtc_minute_in,
  input wire logic [7:0] clock_control_register_in,
  input wire logic int_ack_in,
  input wire logic reti_in,
  output logic int_req_out,
  output logic [15:0] int_vector_out,
  output logic [3:0] timer_flag_clr_out,
  output logic wakeup_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ien_a_r, ien_b_r, ipr_a_r, ipr_b_r, wud_r, pol_r;
  logic [7:0] req_r, req_nxt;
  logic [1:0] misc_r;
  logic [4:0] pin_s1_r, pin_s2_r;
  logic [2:0] fs_cnt_r;
  logic fs_prev_r;
  logic fs_tick;
  tlv_level_t level_r;
  logic low_saved_r;
  tlv_req_t pick;
  logic [NSRC-1:0] pend, prio;
  logic [4:0] pin_act;
  logic [7:0] req_set;
  logic wr_req, wr_misc;
  logic hi_pend, rtc_allowed, xwu_wr_bit;

  assign wr_req = sfr_wr_in && sfr_addr_in == TLV_ADDR_REQ;
  assign wr_misc = sfr_wr_in && sfr_addr_in == TLV_ADDR_MISC;
  assign hi_pend = |(pend & prio);
  assign rtc_allowed = clock_control_register_in[TLV_CLOCK_CONTROL_REGISTER_NORMAL_BIT];
  assign xwu_wr_bit = sfr_wdata_in[TLV_MISC_XWU_BIT];

  // Plain config registers
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ien_a_r <= TLV_RST_REG;
      ien_b_r <= TLV_RST_REG;
      ipr_a_r <= TLV_RST_REG;
      ipr_b_r <= TLV_RST_REG;
      wud_r <= TLV_RST_REG;
      pol_r <= TLV_RST_REG;
    end else if (sfr_wr_in) begin
      unique case (sfr_addr_in)
        TLV_ADDR_IEN_A: ien_a_r <= sfr_wdata_in;
        TLV_ADDR_IEN_B: ien_b_r <= sfr_wdata_in;
        TLV_ADDR_IPR_A: ipr_a_r <= {1'b0, sfr_wdata_in[6:0]};
        TLV_ADDR_IPR_B: ipr_b_r <= sfr_wdata_in;
        TLV_ADDR_WUD: wud_r <= sfr_wdata_in;
        TLV_ADDR_POL: pol_r <= sfr_wdata_in;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Pin synchroniser and polarity
  // ****************************************************************
  // Pins are asynchronous; the first stage only feeds the second
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // Idle level of active-low pins, so reset raises no false flag
      pin_s1_r <= TLV_PIN_IDLE;
      pin_s2_r <= TLV_PIN_IDLE;
    end else begin
      pin_s1_r <= port_one_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Polarity one: active high; zero: active low
  assign pin_act = ~(pin_s2_r ^ pol_r[4:0]);

  // ****************************************************************
  // Frame-sync divider
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fs_prev_r <= 1'b0;
      fs_cnt_r <= 3'h0;
    end else begin
      fs_prev_r <= primary_frame_sync_in;
      if (primary_frame_sync_in && !fs_prev_r) begin
        fs_cnt_r <= fs_tick ? 3'h0 : fs_cnt_r + 3'h1;
      end
    end
  end
  assign fs_tick = primary_frame_sync_in && !fs_prev_r &&
    fs_cnt_r == (fs_fast_in ? TLV_FS_DIV_FAST : TLV_FS_DIV_SLOW);

  // ****************************************************************
  // Request flags
  // ****************************************************************
  always_comb begin
    req_set = {rtc_minute_in,
      dsp_to_core_request_in | dsp_transmit_control_wr_in,
      time_event_in, pin_act};
    // Set wins over a software clear in the same cycle
    req_nxt = (wr_req ? sfr_wdata_in & req_r : req_r) | req_set;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_r <= TLV_RST_REG;
    end else begin
      req_r <= req_nxt;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      misc_r <= 2'b00;
    end else begin
      misc_r[TLV_MISC_FS_BIT] <= fs_tick |
        (wr_misc ? sfr_wdata_in[TLV_MISC_FS_BIT] & misc_r[TLV_MISC_FS_BIT]
                 : misc_r[TLV_MISC_FS_BIT]);
      if (wr_misc) begin
        misc_r[TLV_MISC_XWU_BIT] <= sfr_wdata_in[TLV_MISC_XWU_BIT];
      end
    end
  end

  // ****************************************************************
  // Pending vector and polling
  // ****************************************************************
  always_comb begin
    pend = {req_r[7] & clock_control_register_in[TLV_CLOCK_CONTROL_REGISTER_NORMAL_BIT],
      req_r[6], i2c_irq_in, req_r[4:0], misc_r[TLV_MISC_FS_BIT],
      req_r[5], modem_serial_irq_in, timer_one_irq_in, !ext_pin_one_n_in,
      timer_zero_irq_in, !ext_pin_zero_n_in};
    pend = pend & {ien_b_r, ien_a_r[6:0]} &
      {NSRC{ien_a_r[TLV_GLOBAL_EN_BIT]}};
    prio = {ipr_b_r, ipr_a_r[6:0]};
  end

  // Fixed priority walk: a high pending source beats any low one
  always_comb begin
    logic [3:0] s;
    s = 4'h0;
    pick = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      s = TLV_POLL_ORDER[4*i +: 4];
      if (pend[s] && !prio[s] && level_r == ST_IDLE) begin
        pick = '{valid: 1'b1, src: s, high: 1'b0};
      end
    end
    for (int i = NSRC - 1; i >= 0; i--) begin
      s = TLV_POLL_ORDER[4*i +: 4];
      if (pend[s] && prio[s] && level_r != ST_HIGH) begin
        pick = '{valid: 1'b1, src: s, high: 1'b1};
      end
    end
  end

  // ****************************************************************
  // Service level tracking and outputs
  // ****************************************************************
  // A high handler may preempt a low one; only one level is stacked
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      level_r <= ST_IDLE;
      low_saved_r <= 1'b0;
    end else if (int_ack_in && int_req_out) begin
      low_saved_r <= level_r == ST_LOW;
      level_r <= (int_vector_out[15] ? ST_HIGH : ST_LOW);
    end else if (reti_in) begin
      level_r <= (level_r == ST_HIGH && low_saved_r) ? ST_LOW : ST_IDLE;
      low_saved_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_req_out <= 1'b0;
      int_vector_out <= 16'h0000;
      timer_flag_clr_out <= 4'h0;
    end else begin
      int_req_out <= pick.valid && !(int_ack_in && int_req_out);
      // Bit 15 is never a real vector bit; it carries the level
      int_vector_out <= {pick.high, TLV_VEC_BASE[14:0] +
        (15'(pick.src) << TLV_VEC_STEP_SHIFT)};
      timer_flag_clr_out <= 4'h0;
      if (int_ack_in && int_req_out) begin
        unique case (int_vector_out[14:0])
          15'h0003: timer_flag_clr_out <= 4'h1;
          15'h000b: timer_flag_clr_out <= 4'h2;
          15'h0013: timer_flag_clr_out <= 4'h4;
          15'h001b: timer_flag_clr_out <= 4'h8;
          default: ;
        endcase
      end
    end
  end

  // Wake on any request flag not disabled for wake-up, whether its source is enabled or not
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wakeup_out <= 1'b0;
      sfr_rdata_out <= 8'h00;
    end else begin
      wakeup_out <= |(req_nxt & ~wud_r);
      unique case (sfr_addr_in)
        TLV_ADDR_IEN_A: sfr_rdata_out <= ien_a_r;
        TLV_ADDR_IEN_B: sfr_rdata_out <= ien_b_r;
        TLV_ADDR_IPR_A: sfr_rdata_out <= ipr_a_r;
        TLV_ADDR_IPR_B: sfr_rdata_out <= ipr_b_r;
        TLV_ADDR_WUD: sfr_rdata_out <= wud_r;
        TLV_ADDR_POL: sfr_rdata_out <= pol_r;
        TLV_ADDR_REQ: sfr_rdata_out <= req_r;
        TLV_ADDR_MISC: sfr_rdata_out <= {6'h00, misc_r};
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence ack_taken_s;
    int_ack_in && int_req_out;
  endsequence
  // Ack wins over a return in the same cycle
  sequence reti_seen_s;
    reti_in && !(int_ack_in && int_req_out);
  endsequence
  // Pin seen twice, polarity steady until the flag can take it
  sequence pin0_held_s;
    pol_r[0] && port_one_in[0] ##1 port_one_in[0] && pol_r[0] ##1 pol_r[0];
  endsequence

  global_gate_a: assert property (!ien_a_r[7] |=> !int_req_out)
    else $error("request with global enable clear");
  flag_hold_a: assert property ($rose(req_r[0]) && !wr_req |=> req_r[0])
    else $error("flag lost without write");
  level_reset_a: assert property (wr_req && pin_act[0] |=> req_r[0])
    else $error("active pin flag cleared");
  vec_range_a: assert property (int_req_out |-> int_vector_out[14:0] <= 15'h0073 &&
    int_vector_out[2:0] == 3'h3)
    else $error("bad vector");
  sync_delay_a: assert property (pin0_held_s |=> req_r[0])
    else $error("pin edge not flagged");
  timer_clr_a: assert property (timer_flag_clr_out != 4'h0 |-> $past(int_ack_in))
    else $error("timer clear without ack");
  dsp_event_a: assert property (dsp_to_core_request_in |=> req_r[6])
    else $error("dsp event missed");
  rtc_event_a: assert property (rtc_minute_in |=> req_r[7])
    else $error("rtc event missed");
  high_first_a: assert property (int_req_out && !int_vector_out[15] |->
    !$past(hi_pend))
    else $error("low chosen over high");
  ack_drop_a: assert property (ack_taken_s |=> !int_req_out)
    else $error("request held after ack");
  low_block_a: assert property (level_r != ST_IDLE && int_req_out |->
    int_vector_out[15])
    else $error("low request inside a handler");
  high_block_a: assert property (level_r == ST_HIGH |-> !int_req_out)
    else $error("request inside high handler");
  reti_idle_a: assert property (reti_seen_s ##0 level_r != ST_IDLE &&
    !low_saved_r |=> level_r == ST_IDLE)
    else $error("level kept after return");
  ext0_first_a: assert property (level_r == ST_IDLE && pend[SRC_EXT0] &&
    !hi_pend |=> int_vector_out == {1'b0, TLV_VEC_BASE[14:0]})
    else $error("ext0 not polled first");
  clr_timer_a: assert property (ack_taken_s ##0
    int_vector_out[14:0] == 15'h000b |=> timer_flag_clr_out == 4'h2)
    else $error("timer0 flag not cleared");
  clr_none_a: assert property (ack_taken_s ##0
    int_vector_out[14:0] > 15'h001b |=> timer_flag_clr_out == 4'h0)
    else $error("timer flag cleared for other source");
  rtc_mode_a: assert property (int_req_out && int_vector_out[14:0] ==
    15'h0073 |-> $past(rtc_allowed))
    else $error("rtc request in emergency mode");
  rtc_wake_a: assert property (rtc_minute_in && !wud_r[TLV_REQ_RTC_BIT] |=>
    wakeup_out)
    else $error("rtc event did not wake");
  dtc_event_a: assert property (dsp_transmit_control_wr_in |=>
    req_r[TLV_REQ_DSP_BIT])
    else $error("transmit control write missed");
  time_event_a: assert property (time_event_in |=>
    req_r[TLV_REQ_TIME_BIT])
    else $error("time event missed");
  time_clear_a: assert property ($fell(req_r[TLV_REQ_TIME_BIT]) |->
    $past(wr_req))
    else $error("flag cleared without write");
  fs_flag_a: assert property (fs_tick |=> misc_r[TLV_MISC_FS_BIT])
    else $error("frame flag not set");
  fs_clear_a: assert property ($fell(misc_r[TLV_MISC_FS_BIT]) |->
    $past(wr_misc))
    else $error("frame flag cleared without write");
  xwu_write_a: assert property (wr_misc |=>
    misc_r[TLV_MISC_XWU_BIT] == $past(xwu_wr_bit))
    else $error("wake-up bit write lost");

endmodule : tlv_int_unit

// ==== common/tlv_pkg.sv ====
/*
  Package for the two-level vectored interrupt unit: register addresses,
  reset values, bit positions, source numbering and vector layout.
  Assumes an 8-bit special-function-register port on the core side.
*/
package tlv_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [7:0] TLV_ADDR_IEN_A = 8'ha8;
  localparam logic [7:0] TLV_ADDR_IPR_A = 8'hb8;
  localparam logic [7:0] TLV_ADDR_WUD = 8'hb9;
  localparam logic [7:0] TLV_ADDR_REQ = 8'hc0;
  localparam logic [7:0] TLV_ADDR_MISC = 8'hc1;
  localparam logic [7:0] TLV_ADDR_IEN_B = 8'he8;
  localparam logic [7:0] TLV_ADDR_POL = 8'he9;
  localparam logic [7:0] TLV_ADDR_IPR_B = 8'hf8;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] TLV_RST_REG = 8'h00;
  localparam int TLV_GLOBAL_EN_BIT = 7;
  localparam int TLV_MISC_FS_BIT = 0;
  localparam int TLV_MISC_XWU_BIT = 1;
  localparam int TLV_REQ_TIME_BIT = 5;
  localparam int TLV_REQ_DSP_BIT = 6;
  localparam int TLV_REQ_RTC_BIT = 7;
  localparam int TLV_CLOCK_CONTROL_REGISTER_NORMAL_BIT = 7;

  // ****************************************************************
  // Sources, numbered by vector slot
  // ****************************************************************
  localparam int TLV_NSRC = 15;
  localparam int TLV_NUM_EXT_PINS = 5;
  localparam logic [4:0] TLV_PIN_IDLE = 5'h1f;
  typedef enum logic [3:0] {
    SRC_EXT0 = 4'h0, SRC_TMR0 = 4'h1, SRC_EXT1 = 4'h2, SRC_TMR1 = 4'h3,
    SRC_MODEM = 4'h4, SRC_TIME = 4'h5, SRC_FSYNC = 4'h6, SRC_EXT2 = 4'h7,
    SRC_EXT3 = 4'h8, SRC_EXT4 = 4'h9, SRC_EXT5 = 4'ha, SRC_EXT6 = 4'hb,
    SRC_I2C = 4'hc, SRC_DSP = 4'hd, SRC_RTC = 4'he
  } tlv_src_t;

  // Polling order within a level, rightmost entry (index zero) polled first
  localparam logic [4*TLV_NSRC-1:0] TLV_POLL_ORDER = {
    4'he, 4'h9, 4'h4, 4'hd, 4'h8, 4'h3, 4'hc, 4'h7,
    4'h2, 4'hb, 4'h6, 4'h1, 4'ha, 4'h5, 4'h0};

  localparam logic [15:0] TLV_VEC_BASE = 16'h0003;
  localparam int TLV_VEC_STEP_SHIFT = 3;

  // Frame-sync divider: default one eighth, fast mode one quarter
  localparam logic [2:0] TLV_FS_DIV_SLOW = 3'h7;
  localparam logic [2:0] TLV_FS_DIV_FAST = 3'h3;

  typedef struct packed {
    logic valid;
    logic [3:0] src;
    logic high;
  } tlv_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b11
  } tlv_level_t;

endpackage : tlv_pkg

// ==== sim/tlv_core_model.sv ====
/*
  Core and timer stand-in: takes vectors, returns from handlers on command.
  Assumes the unit's request, vector and timer-clear ports.
*/
`timescale 1ns/1ns
module tlv_core_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic int_req_in,
  input wire logic [15:0] int_vector_in,
  input wire logic [3:0] timer_flag_clr_in,
  input wire logic ret_go_in,
  input wire logic tmr0_set_in,
  output logic int_ack_out,
  output logic reti_out,
  output logic tmr0_irq_out,
  output logic [15:0] vec_out,
  output logic [7:0] take_cnt_out
);
  // ****************************************************************
  // Vector fetch and handler return
  // ****************************************************************
  // Ack at most every other cycle: the request drops one cycle late
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_ack_out <= 1'b0;
      vec_out <= 16'h0000;
      take_cnt_out <= 8'h00;
    end else begin
      int_ack_out <= int_req_in && !int_ack_out;
      if (int_req_in && !int_ack_out) begin
        vec_out <= int_vector_in;
        take_cnt_out <= take_cnt_out + 8'h01;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reti_out <= 1'b0;
    end else begin
      reti_out <= ret_go_in;
    end
  end
  // Timer holds its flag until the unit clears it on service
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmr0_irq_out <= 1'b0;
    end else if (tmr0_set_in) begin
      tmr0_irq_out <= 1'b1;
    end else if (timer_flag_clr_in[1]) begin
      tmr0_irq_out <= 1'b0;
    end
  end
endmodule : tlv_core_model

// ==== sim/two_level_vectored_interrupt_unit_tb_top.sv ====
/*
  Testbench for the interrupt unit: SFR tasks and directed sequences.
  Assumes the core stand-in acks every request it sees.
*/
`timescale 1ns/1ns
module two_level_vectored_interrupt_unit_tb_top;
  import tlv_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, ack, reti, req, wake;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, clock_control_register = 8'h80, cnt0;
  logic [4:0] port1 = 5'h1f;
  logic tmr1 = 1'b0, modem = 1'b0, i2c = 1'b0, timev = 1'b0, pfs = 1'b0;
  logic fsf = 1'b0, dspr = 1'b0, dtcw = 1'b0, rtc = 1'b0, ret_go = 1'b0;
  logic tmr0_set = 1'b0, tmr0;
  logic ext0_n = 1'b1, ext1_n = 1'b1;
  logic [15:0] vec, tvec;
  logic [3:0] clr;
  logic [7:0] tcnt;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  logic [7:0] regs [8] = '{TLV_ADDR_IEN_A, TLV_ADDR_IPR_A, TLV_ADDR_WUD,
    TLV_ADDR_REQ, TLV_ADDR_MISC, TLV_ADDR_IEN_B, TLV_ADDR_POL,
    TLV_ADDR_IPR_B};
  always #50 clk = ~clk;
  tlv_int_unit i_tlv_int_unit (.core_clk_in(clk), .nrst_in(nrst),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr),
    .sfr_rdata_out(rdata), .port_one_in(port1), .ext_pin_zero_n_in(ext0_n),
    .ext_pin_one_n_in(ext1_n), .timer_zero_irq_in(tmr0),
    .timer_one_irq_in(tmr1), .modem_serial_irq_in(modem),
    .i2c_irq_in(i2c), .time_event_in(timev), .primary_frame_sync_in(pfs),
    .fs_fast_in(fsf), .dsp_to_core_request_in(dspr),
    .dsp_transmit_control_wr_in(dtcw), .rtc_minute_in(rtc),
    .clock_control_register_in(clock_control_register), .int_ack_in(ack), .reti_in(reti),
    .int_req_out(req), .int_vector_out(vec), .timer_flag_clr_out(clr),
    .wakeup_out(wake));
  tlv_core_model i_tlv_core_model (.clk_in(clk), .nrst_in(nrst),
    .int_req_in(req), .int_vector_in(vec), .timer_flag_clr_in(clr),
    .ret_go_in(ret_go), .tmr0_set_in(tmr0_set), .int_ack_out(ack),
    .reti_out(reti), .tmr0_irq_out(tmr0), .vec_out(tvec),
    .take_cnt_out(tcnt));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Strobe is lowered and an edge let pass, so calls may follow directly
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk("sfr read", {8'h00, e}, {8'h00, rdata});
    @(posedge clk);
  endtask : rd_reg
  task automatic ret;
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    tick(6);
  endtask : ret
  // Time and DSP events together; first handler clears its own flag
  task automatic fire(input logic [7:0] ipb, input logic via_dtc,
    input logic [15:0] v1, input logic [7:0] m1, input logic [15:0] v2);
    wr_reg(TLV_ADDR_IPR_B, ipb);
    cnt0 = tcnt;
    timev <= 1'b1;
    dspr <= !via_dtc;
    dtcw <= via_dtc;
    @(posedge clk);
    {timev, dspr, dtcw} <= 3'b000;
    tick(6);
    chk("first vector", v1, tvec);
    wr_reg(TLV_ADDR_REQ, m1);
    tick(6);
    chk("no nesting", {8'h00, cnt0 + 8'h01}, {8'h00, tcnt});
    ret;
    chk("second vector", v2, tvec);
    wr_reg(TLV_ADDR_REQ, 8'h9f);
    ret;
  endtask : fire
  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    tick(4);
    nrst <= 1'b1;
    tick(2);
    foreach (regs[i]) rd_reg(regs[i], TLV_RST_REG);
    wr_reg(8'h90, 8'hff);
    rd_reg(8'h90, 8'h00);
    wr_reg(TLV_ADDR_IPR_A, 8'hff);
    rd_reg(TLV_ADDR_IPR_A, 8'h7f);
    wr_reg(TLV_ADDR_IPR_A, 8'h00);
    wr_reg(TLV_ADDR_IEN_B, 8'h80);
    rtc <= 1'b1;
    @(posedge clk);
    rtc <= 1'b0;
    tick(6);
    chk("global off", 16'h0000, {15'h0000, req});
    chk("wake", 16'h0001, {15'h0000, wake});
    rd_reg(TLV_ADDR_REQ, 8'h80);
    wr_reg(TLV_ADDR_IEN_A, 8'h80);
    tick(6);
    chk("rtc vector", 16'h0073, tvec);
    rd_reg(TLV_ADDR_REQ, 8'h80);
    wr_reg(TLV_ADDR_REQ, 8'h7f);
    rd_reg(TLV_ADDR_REQ, 8'h00);
    ret;
    clock_control_register <= 8'h00;
    cnt0 = tcnt;
    rtc <= 1'b1;
    @(posedge clk);
    rtc <= 1'b0;
    tick(6);
    chk("emergency", {8'h00, cnt0}, {8'h00, tcnt});
    wr_reg(TLV_ADDR_REQ, 8'h7f);
    clock_control_register <= 8'h80;
    wr_reg(TLV_ADDR_IEN_A, 8'ha0);
    wr_reg(TLV_ADDR_IEN_B, 8'h40);
    fire(8'h00, 1'b0, 16'h002b, 8'hdf, 16'h006b);
    fire(8'h40, 1'b1, 16'h806b, 8'hbf, 16'h002b);
    wr_reg(TLV_ADDR_IEN_A, 8'h07);
    {tmr0_set, ext0_n, ext1_n} <= 3'b100;
    @(posedge clk);
    tmr0_set <= 1'b0;
    wr_reg(TLV_ADDR_IEN_A, 8'h87);
    tick(6);
    chk("ext0 first", 16'h0003, tvec);
    chk("timer held", 16'h0001, {15'h0000, tmr0});
    ext0_n <= 1'b1;
    ret;
    chk("timer vector", 16'h000b, tvec);
    chk("timer cleared", 16'h0000, {15'h0000, tmr0});
    ret;
    chk("ext1 vector", 16'h0013, tvec);
    ext1_n <= 1'b1;
    ret;
    wr_reg(TLV_ADDR_IEN_A, 8'h00);
    wr_reg(TLV_ADDR_POL, 8'h01);
    tick(4);
    rd_reg(TLV_ADDR_REQ, 8'h01);
    wr_reg(TLV_ADDR_REQ, 8'hfe);
    rd_reg(TLV_ADDR_REQ, 8'h01);
    wr_reg(TLV_ADDR_WUD, 8'h01);
    tick(2);
    chk("wake disabled", 16'h0000, {15'h0000, wake});
    port1 <= 5'h1e;
    tick(4);
    wr_reg(TLV_ADDR_REQ, 8'hfe);
    rd_reg(TLV_ADDR_REQ, 8'h00);
    for (int f = 0; f < 2; f++) begin
      fsf <= f[0];
      wr_reg(TLV_ADDR_MISC, 8'h00);
      for (int k = 1; k <= (f == 1 ? 4 : 8); k++) begin
        pfs <= 1'b1;
        tick(1);
        pfs <= 1'b0;
        tick(2);
        if (k >= 3) rd_reg(TLV_ADDR_MISC,
          k == (f == 1 ? 4 : 8) ? 8'h01 : 8'h00);
      end
    end
    tally_and_finish;
  end
endmodule : two_level_vectored_interrupt_unit_tb_top
